// *** include/mcsp_pkg.sv ***
// Constants and types for the module control and status pin supervisor
//
// Operation
// RULE1 - Transmitter goes dark within 10 us of transmit disable rising.
// RULE2 - Transmitter is back above 90 percent within 2 ms of disable falling.
// RULE3 - Initialization completes within 300 ms of power-on or reset release.
// RULE4 - Interrupt output asserts within 200 ms of its triggering condition.
// RULE5 - Interrupt output negates within 500 us of the host clearing flags.
// RULE6 - Power-down state is entered within 100 us of power-down initiation.
// RULE7 - Not-ready output asserts within 1 ms of a module fault.
// RULE8 - Not-ready output negates within 1 ms of the fault clearing.
// RULE9 - Host holds power-down/reset high at least 10 us to request reset.
// RULE10 - Receive-loss output asserts within 100 us of signal loss.
// RULE11 - Receive-loss output negates within 100 us of signal return.
// RULE12 - Falling edge of power-down/reset starts a complete module reset.
// RULE13 - Power-down/reset high holds low-power standby; management bus stays working.
// RULE14 - In power-down only the reset-complete flag may set.
// RULE15 - Outside power-down, outputs are valid before reset-complete flag rises.
// RULE16 - Every response interval is timed by clock-derived counters with margin; the code counts init, laser settle, receive-loss filter and reset pulse only.
// RULE17 - Host-driven pins are synchronized and qualified before use.
package mcsp_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ = 100;

  // Documented limits
  localparam int unsigned T_OFF_US       = 10;
  localparam int unsigned T_ON_MS        = 2;
  localparam int unsigned T_INIT_MS      = 300;
  localparam int unsigned RESET_PULSE_US = 10;
  localparam int unsigned LOS_LIMIT_US   = 100;

  // Chosen response times, each inside its limit
  localparam int unsigned LASER_SETTLE_US = 1000;
  localparam int unsigned INIT_TIME_MS    = 100;
  localparam int unsigned LOS_FILTER_US   = 20;

  // Derived cycle counts (least time rounds up: whole microseconds here)
  localparam int unsigned RESET_PULSE_CYC  = RESET_PULSE_US * CLK_MHZ;
  localparam int unsigned LASER_SETTLE_CYC = LASER_SETTLE_US * CLK_MHZ;
  localparam int unsigned INIT_CYC         = INIT_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned LOS_FILTER_CYC   = LOS_FILTER_US * CLK_MHZ;

  // Register byte offsets
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_MASK    = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_STATE   = 8'h0c;

  // Event bit positions in status and mask
  localparam int unsigned EV_RESET_DONE = 0;
  localparam int unsigned EV_NOT_READY  = 1;
  localparam int unsigned EV_LOS        = 2;
  localparam int unsigned EV_ALARM      = 3;
  localparam int unsigned EV_W          = 4;

  // Control bit positions
  localparam int unsigned CTL_SOFT_TX_DIS = 0;

  // Reset values
  localparam logic [3:0] MASK_RST    = 4'h0;
  localparam logic [3:0] STATUS_RST  = 4'h0;
  localparam logic [1:0] DONE_PIPE_W = 2'h3;

  typedef enum logic [1:0] {
    MCSP_INIT  = 2'b00,
    MCSP_RUN   = 2'b01,
    MCSP_POWER = 2'b10
  } mcsp_state_t;

  // Synchronized pin group, in synchronizer bit order
  typedef struct packed {
    logic alarm;
    logic signal_lost;
    logic fault;
    logic power_down;
    logic tx_disable;
  } mcsp_pins_t;

  // Readable state word
  typedef struct packed {
    logic       receive_signal_lost;
    logic       module_not_ready;
    logic       laser_on;
    logic [1:0] state;
  } mcsp_view_t;

endpackage : mcsp_pkg

// *** logic/mcsp_supervisor.sv ***
// Control and status pin supervisor with an AHB-Lite register slave
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
module mcsp_supervisor #(
  parameter int unsigned INIT_CYCLES  = mcsp_pkg::INIT_CYC,
  parameter int unsigned SETTLE_CYCLES = mcsp_pkg::LASER_SETTLE_CYC,
  parameter int unsigned LOS_CYCLES   = mcsp_pkg::LOS_FILTER_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Host-driven pins and internal asynchronous conditions
  input  wire logic        tx_disable_pin,
  input  wire logic        power_down_pin,
  input  wire logic        fault_in,
  input  wire logic        signal_lost_in,
  input  wire logic        alarm_in,
  // Transmitter control and low-power state
  output logic             laser_on,
  output logic             low_power,
  // Open-drain status pins
  output logic             interrupt_out,
  output logic             interrupt_oe,
  output logic             module_not_ready_out,
  output logic             module_not_ready_oe,
  output logic             receive_signal_lost_out,
  output logic             receive_signal_lost_oe,
  // Level interrupt to local processor
  output logic             irq
);

  localparam logic [31:0] RESET_PULSE_CYC_W = 32'(mcsp_pkg::RESET_PULSE_CYC);

  logic [4:0]            sync1;
  logic [4:0]            sync2;
  mcsp_pkg::mcsp_pins_t  pins;
  logic                  pdown_prev;
  logic                  pdown_fall;
  logic [31:0]           pdown_cnt;
  logic                  reset_req;
  logic                  short_pulse;
  mcsp_pkg::mcsp_state_t state;
  logic [31:0]           init_cnt;
  logic [1:0]            done_pipe;
  logic                  laser_allowed;
  logic [31:0]           settle_cnt;
  logic                  module_not_ready;
  logic                  receive_signal_lost;
  logic [31:0]           los_cnt;
  logic                  alarm_prev;
  logic [3:0]            status;
  logic [3:0]            mask;
  logic                  any_pending;
  logic                  soft_tx_dis;
  logic [3:0]            events;
  logic                  wr_pend;
  logic [7:0]            wr_addr;
  logic                  addr_ok;
  logic [31:0]           next_rdata;
  mcsp_pkg::mcsp_view_t  view;

  function automatic logic [31:0] dec_sat(input logic [31:0] v);
    dec_sat = (v == 32'h0) ? 32'h0 : v - 32'h1;
  endfunction : dec_sat

  // Last cycle of an interval of lim cycles
  function automatic logic reached(input logic [31:0] cnt, input logic [31:0] lim);
    reached = (cnt >= lim - 32'h1);
  endfunction : reached

  // Two-flop synchronizers for every asynchronous input
  always_ff @(posedge hclk or negedge hresetn) begin // RULE17
    if (!hresetn) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {alarm_in, signal_lost_in, fault_in, power_down_pin, tx_disable_pin};
      sync2 <= sync1;
    end
  end
  assign pins = sync2;

  // Power-down pulse length qualification
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pdown_prev <= 1'b0;
      pdown_cnt  <= 32'h0;
    end else begin
      pdown_prev <= pins.power_down;
      if (!pins.power_down) begin
        pdown_cnt <= 32'h0;
      end else if (pdown_cnt < RESET_PULSE_CYC_W) begin
        pdown_cnt <= pdown_cnt + 32'h1; // RULE9
      end
    end
  end

  // Falling edge of the synchronized power-down pin
  assign pdown_fall  = pdown_prev && !pins.power_down;
  assign reset_req   = pdown_fall && (pdown_cnt >= RESET_PULSE_CYC_W); // RULE9 RULE17
  assign short_pulse = pdown_fall && (pdown_cnt < RESET_PULSE_CYC_W);

  // Module state: initialization, running, power-down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= mcsp_pkg::MCSP_INIT;
      init_cnt <= 32'h0;
    end else begin
      unique case (state)
        mcsp_pkg::MCSP_INIT: begin
          if (reset_req) begin
            init_cnt <= 32'h0; // RULE12
          end else if (reached(init_cnt, INIT_CYCLES)) begin
            init_cnt <= 32'h0; // RULE3
            state    <= pins.power_down ? mcsp_pkg::MCSP_POWER : mcsp_pkg::MCSP_RUN;
          end else begin
            init_cnt <= init_cnt + 32'h1; // RULE16
          end
        end
        mcsp_pkg::MCSP_RUN: begin
          if (pins.power_down) begin
            state <= mcsp_pkg::MCSP_POWER; // RULE6 RULE13
          end
        end
        mcsp_pkg::MCSP_POWER: begin
          if (reset_req) begin
            state <= mcsp_pkg::MCSP_INIT; // RULE12
          end else if (short_pulse) begin
            state <= mcsp_pkg::MCSP_RUN;
          end
        end
        default: begin
          state <= mcsp_pkg::MCSP_INIT;
        end
      endcase
    end
  end

  // Reset-complete flag delayed until pins show valid values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_pipe <= 2'h0;
    end else begin
      done_pipe[0] <= (state == mcsp_pkg::MCSP_INIT) && reached(init_cnt, INIT_CYCLES) && !reset_req;
      done_pipe[1] <= done_pipe[0]; // RULE15
    end
  end

  // Transmitter: off at once, on after a settle time
  assign laser_allowed = (state == mcsp_pkg::MCSP_RUN) && !pins.tx_disable && !soft_tx_dis;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      laser_on   <= 1'b0;
      settle_cnt <= 32'h0;
    end else if (!laser_allowed) begin
      laser_on   <= 1'b0; // RULE1
      settle_cnt <= SETTLE_CYCLES;
    end else begin
      settle_cnt <= dec_sat(settle_cnt);
      laser_on   <= (settle_cnt == 32'h0); // RULE2 RULE16
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_power <= 1'b0;
    end else begin
      low_power <= (state == mcsp_pkg::MCSP_POWER); // RULE6 RULE13
    end
  end

  // Not-ready follows the fault and the module state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_not_ready <= 1'b1;
    end else begin
      module_not_ready <= (state != mcsp_pkg::MCSP_RUN) || pins.fault; // RULE7 RULE8
    end
  end

  // Receive-loss with a short persistence filter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      receive_signal_lost <= 1'b1;
      los_cnt             <= 32'h0;
    end else if (pins.signal_lost == receive_signal_lost) begin
      los_cnt <= 32'h0;
    end else if (reached(los_cnt, LOS_CYCLES)) begin
      los_cnt             <= 32'h0;
      receive_signal_lost <= pins.signal_lost; // RULE10 RULE11
    end else begin
      los_cnt <= los_cnt + 32'h1; // RULE16
    end
  end

  // Events; in power-down only reset completion may flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_prev <= 1'b0;
    end else begin
      alarm_prev <= pins.alarm;
    end
  end

  always_comb begin
    events                          = 4'h0;
    events[mcsp_pkg::EV_RESET_DONE] = done_pipe[1]; // RULE15
    if (state == mcsp_pkg::MCSP_RUN) begin // RULE14
      events[mcsp_pkg::EV_NOT_READY] = module_not_ready != (pins.fault);
      events[mcsp_pkg::EV_LOS]       = (pins.signal_lost != receive_signal_lost) && reached(los_cnt, LOS_CYCLES);
      events[mcsp_pkg::EV_ALARM]     = pins.alarm && !alarm_prev;
    end
  end

  // Bus address phase capture
  assign addr_ok = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Sticky status: set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= mcsp_pkg::STATUS_RST;
    end else begin
      if (wr_pend && wr_addr == mcsp_pkg::ADDR_STATUS) begin
        status <= (status & ~hwdata[3:0]) | events;
      end else begin
        status <= status | events;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask <= mcsp_pkg::MASK_RST;
    end else if (wr_pend && wr_addr == mcsp_pkg::ADDR_MASK) begin
      mask <= hwdata[3:0];
    end
  end

  // Software transmit disable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_tx_dis <= 1'b0;
    end else if (wr_pend && wr_addr == mcsp_pkg::ADDR_CONTROL) begin
      soft_tx_dis <= hwdata[mcsp_pkg::CTL_SOFT_TX_DIS];
    end
  end

  // Read data prepared at the address phase
  assign view = '{receive_signal_lost: receive_signal_lost, module_not_ready: module_not_ready,
                  laser_on: laser_on, state: state};
  always_comb begin
    next_rdata = 32'h0;
    unique case (haddr[7:0])
      mcsp_pkg::ADDR_STATUS:  next_rdata = {28'h0, status};
      mcsp_pkg::ADDR_MASK:    next_rdata = {28'h0, mask};
      mcsp_pkg::ADDR_CONTROL: next_rdata = {31'h0, soft_tx_dis};
      mcsp_pkg::ADDR_STATE:   next_rdata = {27'h0, view};
      default:                next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else begin
      hrdata <= (addr_ok && !hwrite) ? next_rdata : 32'h0;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign any_pending = |(status & mask);

  // Local processor interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= any_pending;
    end
  end

  // Interrupt pin: active-low pull, released pin reads high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_out <= 1'b0;
      interrupt_oe  <= 1'b0;
    end else begin
      interrupt_out <= 1'b0;
      interrupt_oe  <= any_pending; // RULE4 RULE5
    end
  end

  // Not-ready pin: pulled low only while ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_not_ready_out <= 1'b0;
      module_not_ready_oe  <= 1'b0;
    end else begin
      module_not_ready_out <= 1'b0;
      module_not_ready_oe  <= !module_not_ready; // RULE7 RULE8
    end
  end

  // Receive-loss pin: pulled low only while signal present
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      receive_signal_lost_out <= 1'b0;
      receive_signal_lost_oe  <= 1'b0;
    end else begin
      receive_signal_lost_out <= 1'b0;
      receive_signal_lost_oe  <= !receive_signal_lost; // RULE10 RULE11
    end
  end

endmodule : mcsp_supervisor

// *** verification/mcsp_host_model.sv ***
// Host board model: drives control pins, senses open-drain status lines
`timescale 1ns/1ns
module mcsp_host_model (
  // Clock
  input  wire logic hclk,
  // Open-drain enables from the module
  input  wire logic interrupt_oe,
  input  wire logic module_not_ready_oe,
  input  wire logic receive_signal_lost_oe,
  // Host-driven pins
  output logic      tx_disable_pin,
  output logic      power_down_pin,
  // Wire levels with host pull-ups
  output logic      interrupt_n,
  output logic      not_ready_level,
  output logic      signal_lost_level
);
  int unsigned held;

  assign interrupt_n       = ~interrupt_oe;
  assign not_ready_level   = ~module_not_ready_oe;
  assign signal_lost_level = ~receive_signal_lost_oe;

  initial begin
    tx_disable_pin = 1'b0;
    power_down_pin = 1'b0;
  end

  always @(posedge hclk) held <= power_down_pin ? held + 1 : 0;

  task automatic set_tx(input logic v);
    @(posedge hclk) tx_disable_pin <= v;
  endtask : set_tx

  task automatic pd_raise();
    @(posedge hclk) power_down_pin <= 1'b1;
  endtask : pd_raise

  // Release only after the minimum reset hold
  task automatic pd_release();
    while (held < mcsp_pkg::RESET_PULSE_CYC) @(posedge hclk);
    @(posedge hclk) power_down_pin <= 1'b0;
  endtask : pd_release
endmodule : mcsp_host_model

// *** verification/mcsp_supervisor_chk.sv ***
// Port-level timing checker for the pin supervisor
`timescale 1ns/1ns
module mcsp_supervisor_chk #(
  parameter int unsigned INIT_CYCLES   = 200,
  parameter int unsigned SETTLE_CYCLES = 50,
  parameter int unsigned LOS_CYCLES    = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Watched ports
  input wire logic tx_disable_pin,
  input wire logic power_down_pin,
  input wire logic fault_in,
  input wire logic signal_lost_in,
  input wire logic laser_on,
  input wire logic low_power,
  input wire logic module_not_ready_oe,
  input wire logic receive_signal_lost_oe,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq
);
  localparam int ON_MAX  = SETTLE_CYCLES + 8;
  localparam int LOS_MAX = LOS_CYCLES + 6;
  int unsigned init_cnt;

  // Cycles since reset release, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) init_cnt <= 0;
    else if (init_cnt < INIT_CYCLES + 9) init_cnt <= init_cnt + 1;
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  tx_off_a: assert property ($rose(tx_disable_pin) |-> ##[1:4] !laser_on) else $error("laser stays on");
  tx_on_a: assert property ($fell(tx_disable_pin) |-> ##[1:ON_MAX] laser_on) else $error("laser not back");
  pd_enter_a: assert property ($rose(power_down_pin) && laser_on |-> ##[1:6] low_power)
    else $error("no power-down");
  standby_a: assert property (low_power |-> !laser_on) else $error("laser on in standby");
  nr_raise_a: assert property ($rose(fault_in) && laser_on |-> ##[1:6] !module_not_ready_oe)
    else $error("not-ready late");
  nr_clear_a: assert property ($fell(fault_in) && !low_power |-> ##[1:6] module_not_ready_oe)
    else $error("not-ready stuck");
  los_raise_a: assert property ($rose(signal_lost_in) && laser_on |-> ##[1:LOS_MAX] !receive_signal_lost_oe)
    else $error("loss late");
  los_clear_a: assert property ($fell(signal_lost_in) && laser_on |-> ##[1:LOS_MAX] receive_signal_lost_oe)
    else $error("loss stuck");
  init_hold_a: assert property (init_cnt < INIT_CYCLES |-> !laser_on && !module_not_ready_oe)
    else $error("init too short");
  init_done_a: assert property (init_cnt == INIT_CYCLES + 8 && !fault_in |-> module_not_ready_oe)
    else $error("init too long");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or error");

  cover property ($rose(laser_on));
  cover property ($rose(irq));
  cover property ($rose(low_power));
endmodule : mcsp_supervisor_chk

bind mcsp_supervisor mcsp_supervisor_chk #(.INIT_CYCLES(INIT_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES),
  .LOS_CYCLES(LOS_CYCLES)) i_chk (.hclk(hclk), .hresetn(hresetn), .tx_disable_pin(tx_disable_pin),
  .power_down_pin(power_down_pin), .fault_in(fault_in), .signal_lost_in(signal_lost_in), .laser_on(laser_on),
  .low_power(low_power), .module_not_ready_oe(module_not_ready_oe), .receive_signal_lost_oe(receive_signal_lost_oe),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

// *** verification/mcsp_supervisor_tb.sv ***
// Self-checking bench for the pin supervisor
`timescale 1ns/1ns
module mcsp_supervisor_tb;
  localparam int INIT = 200;
  localparam int SET  = 50;
  logic        hclk, hresetn, hsel, hwrite, fault_in, signal_lost_in, alarm_in;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        hreadyout, hresp, laser_on, low_power, irq, int_oe, nr_oe, los_oe, tx_dis, pd, int_n, nr_lvl, los_lvl;
  logic        int_o, nr_o, los_o;
  int          n_fail, n_tests, n_cyc;

  mcsp_supervisor #(.INIT_CYCLES(INIT), .SETTLE_CYCLES(SET), .LOS_CYCLES(10)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_disable_pin(tx_dis), .power_down_pin(pd), .fault_in(fault_in), .signal_lost_in(signal_lost_in),
    .alarm_in(alarm_in), .laser_on(laser_on), .low_power(low_power), .interrupt_out(int_o), .interrupt_oe(int_oe),
    .module_not_ready_out(nr_o), .module_not_ready_oe(nr_oe), .receive_signal_lost_out(los_o),
    .receive_signal_lost_oe(los_oe), .irq(irq));

  mcsp_host_model i_host (.hclk(hclk), .interrupt_oe(int_oe), .module_not_ready_oe(nr_oe),
    .receive_signal_lost_oe(los_oe), .tx_disable_pin(tx_dis), .power_down_pin(pd), .interrupt_n(int_n),
    .not_ready_level(nr_lvl), .signal_lost_level(los_lvl));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic end_of_test();
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  always @(posedge hclk) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 10000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // One AHB-Lite single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic s_init();
    cyc(INIT + 10);
    bus(0, mcsp_pkg::ADDR_STATE, 0);
    chk("state", rd & 32'h1b, 32'h1);
    bus(0, mcsp_pkg::ADDR_STATUS, 0);
    chk("reset done", rd & 32'h1, 32'h1);
    bus(0, mcsp_pkg::ADDR_MASK, 0);
    chk("mask reset", rd, 32'h0);
    bus(1, mcsp_pkg::ADDR_STATUS, 32'hf);
    cyc(SET + 10);
    chk("laser up", laser_on, 1'b1);
  endtask : s_init

  task automatic s_tx();
    i_host.set_tx(1'b1);
    cyc(5);
    chk("laser off", laser_on, 1'b0);
    i_host.set_tx(1'b0);
    cyc(SET + 8);
    chk("laser on", laser_on, 1'b1);
  endtask : s_tx

  task automatic s_irq();
    bus(1, mcsp_pkg::ADDR_MASK, 32'hf);
    alarm_in <= 1'b1;
    cyc(5);
    chk("irq set", irq, 1'b1);
    chk("int pin", int_n, 1'b0);
    chk("open drain low", {29'h0, int_o, nr_o, los_o}, 32'h0);
    bus(1, mcsp_pkg::ADDR_STATUS, 32'h8);
    cyc(3);
    chk("int clear", int_n, 1'b1);
    bus(1, mcsp_pkg::ADDR_MASK, 32'h0);
    alarm_in <= 1'b0;
    cyc(2);
    alarm_in <= 1'b1;
    cyc(5);
    chk("irq masked", irq, 1'b0);
    bus(0, mcsp_pkg::ADDR_STATUS, 0);
    chk("sticky", rd, 32'h8);
    bus(0, 8'h20, 0);
    chk("unmapped", rd, 32'h0);
    alarm_in <= 1'b0;
  endtask : s_irq

  task automatic s_status();
    fault_in <= 1'b1;
    cyc(8);
    chk("nr on", nr_lvl, 1'b1);
    fault_in <= 1'b0;
    cyc(8);
    chk("nr off", nr_lvl, 1'b0);
    signal_lost_in <= 1'b1;
    cyc(20);
    chk("los on", los_lvl, 1'b1);
    signal_lost_in <= 1'b0;
    cyc(20);
    chk("los off", los_lvl, 1'b0);
    bus(1, mcsp_pkg::ADDR_STATUS, 32'hf);
  endtask : s_status

  task automatic s_pd();
    bus(1, mcsp_pkg::ADDR_MASK, 32'h1);
    i_host.pd_raise();
    cyc(8);
    chk("low power", low_power, 1'b1);
    chk("laser dark", laser_on, 1'b0);
    bus(0, mcsp_pkg::ADDR_STATE, 0);
    chk("pd state", rd & 32'h3, 32'h2);
    alarm_in <= 1'b1;
    cyc(5);
    bus(0, mcsp_pkg::ADDR_STATUS, 0);
    chk("pd flags", rd, 32'h0);
    i_host.pd_release();
    cyc(6);
    bus(0, mcsp_pkg::ADDR_STATE, 0);
    chk("restart", rd & 32'h3, 32'h0);
    cyc(INIT + 10);
    bus(0, mcsp_pkg::ADDR_STATE, 0);
    chk("rerun", rd & 32'h1b, 32'h1);
    chk("done irq", irq, 1'b1);
  endtask : s_pd

  initial begin
    {hsel, hwrite, fault_in, signal_lost_in, alarm_in} = '0;
    {haddr, hwdata, htrans, n_fail, n_tests, n_cyc} = '0;
    hresetn = 1'b0;
    cyc(5);
    hresetn <= 1'b1;
    s_init();
    s_tx();
    s_irq();
    s_status();
    s_pd();
    end_of_test();
  end
endmodule : mcsp_supervisor_tb
